// file: design/gam_core_addr.sv
// Input window decode, triangle buffer and linear-to-system address translation
// Notes on behaviour
// R1 - Window splits into registers, triangle data, 2D triangle data, control, low to high.
// R2 - Registers reached over slave port; table fetches use request/acknowledge memory port.
// R3 - Triangle writes enter a FIFO; the writer never waits.
// R4 - Each 4KB page of 32MB linear space maps to any 4KB system page.
// R5 - Table holds one 32-bit word per linear page, 32KB in system memory.
// R6 - Eight static pointer registers each locate one 4KB page of the table.
// R7 - Translation cache holds 256 entries, four-way set associative.
// R8 - After reset translation is bypassed; linear space sits at system address zero.
// R9 - Enabling translation spends 256 cycles initialising the cache first.
// R10 - Enable register shows a ready flag once cache initialisation finishes.
// R11 - Disabling translation returns to the untranslated bypass mapping.
// R12 - Software disables translation, edits the table, then re-enables it.
// R13 - Disable then re-enable invalidates every cached entry.
// R14 - On a miss, upper three index bits pick pointer; fetched word gives page base.
//
// Strobed register access and the address map were decided locally.
module gam_core_addr
  import gam_pkg::*;
#(
  parameter int FIFO_DEPTH = TRI_DEPTH
) (
  input wire logic core_clk, // Core clock, 25 MHz
  input wire logic nrst, // Synchronous reset, active low
  input wire logic [WIN_W-1:0] regAddr, // Byte offset in the input window
  input wire logic [31:0] regWdata, // Write data
  input wire logic regWr, // Write strobe
  input wire logic regRd, // Read strobe
  output logic [31:0] regRdata, // Read data, cycle after strobe
  input wire logic xlReq, // Linear access request, held to ack
  input wire logic [LIN_W-1:0] xlAddr, // Linear byte address
  output logic xlAck, // Translation done pulse
  output logic [31:0] xlPhys, // System byte address
  output logic memReq, // Table fetch request
  output logic [31:0] memAddr, // Table entry address
  input wire logic memAck, // Fetch done
  input wire logic [31:0] memRdata, // Fetched table word
  output logic triValid, // Triangle word available
  output logic [31:0] triData, // Triangle word
  output logic tri2d, // Word came from 2D region
  input wire logic triReady, // Pipeline takes triangle word
  output logic ctrlStrobe, // Accelerator control write pulse
  output logic [WIN_W-1:0] ctrlAddr, // Control write offset
  output logic [31:0] ctrlData, // Control write data
  output logic mmuReady // Translation active and ready
);
  localparam int LVL_W = $clog2(FIFO_DEPTH + 1);
  localparam int PTR_W = $clog2(FIFO_DEPTH);

  if (FIFO_DEPTH < 2 || (FIFO_DEPTH & (FIFO_DEPTH - 1)) != 0) begin : gBadDepth
    $error("gam_core_addr: FIFO_DEPTH must be a power of two, at least 2");
  end

  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------
  function automatic gam_region_t regionOf(input logic [WIN_W-1:0] a);
    if (a >= TRI_CTRL_BASE) begin
      return GAM_TRI_CTRL;
    end else if (a >= TRI_2D_BASE) begin
      return GAM_TRI_2D;
    end else if (a >= TRI_DATA_BASE) begin
      return GAM_TRI_DATA;
    end
    return GAM_REG_SPACE;
  endfunction

  function automatic logic isPtr(input logic [WIN_W-1:0] a, input int i);
    return a == OFF_PTR_BASE + WIN_W'(4 * i);
  endfunction

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  gam_mmu_state_t stateReg, stateNext;
  logic enReg;
  logic [31:0] ptrReg [TBL_PAGES];
  logic [7:0] initCntReg;
  logic ovfReg;
  logic [32:0] fifoMem [FIFO_DEPTH];
  logic [PTR_W-1:0] wrPtrReg, rdPtrReg;
  logic [LVL_W-1:0] levelReg;
  logic [31:0] rdataNext;
  logic [IDX_W-1:0] pendIdxReg;
  logic [PAGE_W-1:0] pendOffReg;

  gam_tlb_if tlbBus ();

  gam_tlb #(
    .SETS(CACHE_SETS),
    .WAYS(CACHE_WAYS)
  ) uTlb (
    .core_clk(core_clk),
    .nrst(nrst),
    .tlb(tlbBus.cache)
  );

  // ----------------------------------------------------------------
  // Window decode
  // ----------------------------------------------------------------
  // Region of each strobe
  wire gam_region_t wrRegion = regionOf(regAddr); // R1
  wire gam_region_t rdRegion = regionOf(regAddr);
  wire regSpaceWr = regWr && (wrRegion == GAM_REG_SPACE); // R2
  wire enWr = regSpaceWr && (regAddr == OFF_MMU_EN);
  wire statusWr = regSpaceWr && (regAddr == OFF_STATUS);
  wire triWr = regWr && (wrRegion == GAM_TRI_DATA || wrRegion == GAM_TRI_2D);
  wire ctrlWr = regWr && (wrRegion == GAM_TRI_CTRL);
  wire enNew = enWr ? regWdata[EN_BIT] : enReg;

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  // Enable and pointer registers
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      enReg <= 1'b0; // R8
      for (int i = 0; i < TBL_PAGES; i++) begin
        ptrReg[i] <= PTR_RESET;
      end
    end else begin
      enReg <= enNew;
      for (int i = 0; i < TBL_PAGES; i++) begin
        if (regSpaceWr && isPtr(regAddr, i)) begin
          ptrReg[i] <= regWdata; // R6
        end
      end
    end
  end

  // Read mux for register space; other regions read zero
  always_comb begin
    rdataNext = 32'h0000_0000;
    if (rdRegion == GAM_REG_SPACE) begin
      if (regAddr == OFF_MMU_EN) begin
        rdataNext[EN_BIT] = enReg;
        rdataNext[READY_BIT] = (stateReg == ST_RUN) || (stateReg == ST_FETCH); // R10
      end else if (regAddr == OFF_STATUS) begin
        rdataNext[OVF_BIT] = ovfReg;
        rdataNext[LEVEL_LSB +: LVL_W] = levelReg;
      end
      for (int i = 0; i < TBL_PAGES; i++) begin
        if (isPtr(regAddr, i)) begin
          rdataNext = ptrReg[i];
        end
      end
    end
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      regRdata <= 32'h0000_0000;
    end else begin
      regRdata <= regRd ? rdataNext : 32'h0000_0000;
    end
  end

  // Accelerator control writes pass out as a pulse
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      ctrlStrobe <= 1'b0;
      ctrlAddr <= '0;
      ctrlData <= 32'h0000_0000;
    end else begin
      ctrlStrobe <= ctrlWr;
      if (ctrlWr) begin
        ctrlAddr <= regAddr;
        ctrlData <= regWdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // Triangle FIFO
  // ----------------------------------------------------------------
  // Output stage loads when empty or taken
  wire fifoFull = (levelReg == LVL_W'(FIFO_DEPTH));
  wire fifoEmpty = (levelReg == '0);
  wire outLoad = !fifoEmpty && (!triValid || triReady);
  wire fifoPush = triWr && !fifoFull; // R3
  wire ovfSet = triWr && fifoFull;

  // Pointers, level and output register
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      wrPtrReg <= '0;
      rdPtrReg <= '0;
      levelReg <= '0;
      triValid <= 1'b0;
      triData <= 32'h0000_0000;
      tri2d <= 1'b0;
    end else begin
      if (fifoPush) begin
        wrPtrReg <= wrPtrReg + PTR_W'(1);
      end
      if (outLoad) begin
        rdPtrReg <= rdPtrReg + PTR_W'(1);
        {tri2d, triData} <= fifoMem[rdPtrReg];
      end
      if (outLoad || triReady) begin
        triValid <= outLoad;
      end
      levelReg <= levelReg + LVL_W'(fifoPush) - LVL_W'(outLoad);
    end
  end

  // Buffer words, no reset needed
  always_ff @(posedge core_clk) begin
    if (fifoPush) begin
      fifoMem[wrPtrReg] <= {wrRegion == GAM_TRI_2D, regWdata}; // R3
    end
  end

  // Overflow flag: a new overflow beats a clear in the same cycle
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      ovfReg <= 1'b0;
    end else begin
      ovfReg <= ovfSet || (ovfReg && !(statusWr && regWdata[OVF_BIT]));
    end
  end

  // ----------------------------------------------------------------
  // Translation control
  // ----------------------------------------------------------------
  // Page index, pointer select, init end
  wire [IDX_W-1:0] reqIdx = xlAddr[LIN_W-1:PAGE_W];
  wire [TBL_SEL_W-1:0] tblSel = reqIdx[IDX_W-1:TBL_WORD_W];
  wire reqNew = xlReq && !xlAck;
  wire initDone = (initCntReg == 8'(INIT_CYCLES - 1));

  // Cache wiring
  assign tlbBus.lkIdx = reqIdx;
  assign tlbBus.clrEn = (stateReg == ST_INIT); // R13
  assign tlbBus.clrSet = initCntReg[7:2];
  assign tlbBus.fillEn = (stateReg == ST_FETCH) && memAck;
  assign tlbBus.fillIdx = pendIdxReg;
  assign tlbBus.fillPpn = memRdata[31:PAGE_W];

  // Next state
  always_comb begin
    stateNext = stateReg;
    unique case (stateReg)
      ST_BYPASS: begin
        if (enNew) begin
          stateNext = ST_INIT; // R9
        end
      end
      ST_INIT: begin
        if (!enNew) begin
          stateNext = ST_BYPASS; // R11
        end else if (initDone) begin
          stateNext = ST_RUN;
        end
      end
      ST_RUN: begin
        if (!enNew) begin
          stateNext = ST_BYPASS; // R11
        end else if (reqNew && !tlbBus.lkHit) begin
          stateNext = ST_FETCH;
        end
      end
      ST_FETCH: begin
        if (memAck) begin
          stateNext = enNew ? ST_RUN : ST_BYPASS;
        end
      end
    endcase
  end

  // State, init counter and ready flag
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      stateReg <= ST_BYPASS; // R8
      initCntReg <= 8'h00;
      mmuReady <= 1'b0;
    end else begin
      stateReg <= stateNext;
      initCntReg <= (stateReg == ST_INIT) ? initCntReg + 8'h01 : 8'h00; // R9
      mmuReady <= (stateNext == ST_RUN) || (stateNext == ST_FETCH); // R10
    end
  end

  // Answers to linear requests and table fetches
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      xlAck <= 1'b0;
      xlPhys <= 32'h0000_0000;
      memReq <= 1'b0;
      memAddr <= 32'h0000_0000;
      pendIdxReg <= '0;
      pendOffReg <= '0;
    end else begin
      xlAck <= 1'b0;
      if (stateReg == ST_BYPASS && reqNew) begin
        xlAck <= 1'b1;
        xlPhys <= {{(32 - LIN_W){1'b0}}, xlAddr}; // R8
      end else if (stateReg == ST_RUN && reqNew && enNew) begin
        if (tlbBus.lkHit) begin
          xlAck <= 1'b1;
          xlPhys <= {tlbBus.lkPpn, xlAddr[PAGE_W-1:0]}; // R4
        end else begin
          memReq <= 1'b1; // R2
          memAddr <= {ptrReg[tblSel][31:PAGE_W], reqIdx[TBL_WORD_W-1:0], 2'b00}; // R14 R5
          pendIdxReg <= reqIdx;
          pendOffReg <= xlAddr[PAGE_W-1:0];
        end
      end else if (stateReg == ST_FETCH && memAck) begin
        memReq <= 1'b0;
        xlAck <= 1'b1;
        xlPhys <= {memRdata[31:PAGE_W], pendOffReg}; // R14
      end
    end
  end
endmodule // gam_core_addr

// file: design/gam_pkg.sv
// Shared constants and types for the graphics core address and translation block
package gam_pkg;
  // ----------------------------------------------------------------
  // Window and address widths
  // ----------------------------------------------------------------
  localparam int WIN_W = 24;
  localparam int LIN_W = 25;
  localparam int PAGE_W = 12;
  localparam int IDX_W = LIN_W - PAGE_W;
  localparam int PPN_W = 32 - PAGE_W;
  localparam int TBL_PAGES = 8;
  localparam int TBL_SEL_W = 3;
  localparam int TBL_WORD_W = IDX_W - TBL_SEL_W;
  localparam int CACHE_SETS = 64;
  localparam int CACHE_WAYS = 4;
  localparam int CACHE_ENTRIES = 256;

  // ----------------------------------------------------------------
  // Region bounds inside the input window
  // ----------------------------------------------------------------
  localparam logic [WIN_W-1:0] TRI_DATA_BASE = 24'h80_0000;
  localparam logic [WIN_W-1:0] TRI_2D_BASE = 24'hA0_0000;
  localparam logic [WIN_W-1:0] TRI_CTRL_BASE = 24'hC0_0000;

  typedef enum logic [1:0] {
    GAM_REG_SPACE = 2'b00,
    GAM_TRI_DATA = 2'b01,
    GAM_TRI_2D = 2'b10,
    GAM_TRI_CTRL = 2'b11
  } gam_region_t;

  // ----------------------------------------------------------------
  // Register offsets and fields
  // ----------------------------------------------------------------
  localparam logic [WIN_W-1:0] OFF_MMU_EN = 24'h00_0000;
  localparam logic [WIN_W-1:0] OFF_PTR_BASE = 24'h00_0010;
  localparam logic [WIN_W-1:0] OFF_STATUS = 24'h00_0030;
  localparam int EN_BIT = 0;
  localparam int READY_BIT = 1;
  localparam int OVF_BIT = 0;
  localparam int LEVEL_LSB = 8;
  localparam logic [31:0] PTR_RESET = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int INIT_CYCLES = 256;
  localparam int TRI_DEPTH = 16;

  typedef enum logic [1:0] {
    ST_BYPASS = 2'b00,
    ST_INIT = 2'b01,
    ST_RUN = 2'b11,
    ST_FETCH = 2'b10
  } gam_mmu_state_t;
endpackage

// file: design/gam_tlb.sv
// Set-associative cache of translation table entries
module gam_tlb
  import gam_pkg::*;
#(
  parameter int SETS = CACHE_SETS,
  parameter int WAYS = CACHE_WAYS
) (
  input wire logic core_clk, // Core clock
  input wire logic nrst, // Synchronous reset, active low
  gam_tlb_if.cache tlb // Lookup, fill and clear
);
  localparam int SET_W = $clog2(SETS);
  localparam int TAG_W = IDX_W - SET_W;

  if (SETS * WAYS != CACHE_ENTRIES || WAYS != 4 || SET_W != 6) begin : gBadGeom
    $error("gam_tlb: geometry must be 64 sets of 4 ways");
  end

  logic validReg [SETS][WAYS];
  logic [TAG_W-1:0] tagReg [SETS][WAYS];
  logic [PPN_W-1:0] ppnReg [SETS][WAYS];
  logic [1:0] victimReg;

  wire [SET_W-1:0] lkSet = tlb.lkIdx[SET_W-1:0];
  wire [TAG_W-1:0] lkTag = tlb.lkIdx[IDX_W-1:SET_W];
  wire [SET_W-1:0] fillSet = tlb.fillIdx[SET_W-1:0];
  wire [TAG_W-1:0] fillTag = tlb.fillIdx[IDX_W-1:SET_W];
  logic [WAYS-1:0] wayHit;
  logic [WAYS-1:0] wayFree;
  logic [1:0] fillWay;

  // ----------------------------------------------------------------
  // Lookup and way choice
  // ----------------------------------------------------------------
  // Compare all four ways of the addressed set
  for (genvar w = 0; w < WAYS; w++) begin : gWay
    assign wayHit[w] = validReg[lkSet][w] && (tagReg[lkSet][w] == lkTag);
    assign wayFree[w] = !validReg[fillSet][w];
  end

  // Hit way data; free way preferred on fill, else round robin
  always_comb begin
    tlb.lkHit = |wayHit;
    tlb.lkPpn = '0;
    fillWay = victimReg;
    for (int w = WAYS - 1; w >= 0; w--) begin
      if (wayHit[w]) begin
        tlb.lkPpn = ppnReg[lkSet][w];
      end
      if (wayFree[w]) begin
        fillWay = 2'(w);
      end
    end
  end

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  // Valid bits: reset, per-set clear during initialisation, fill
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      for (int s = 0; s < SETS; s++) begin
        for (int w = 0; w < WAYS; w++) begin
          validReg[s][w] <= 1'b0;
        end
      end
      victimReg <= 2'b00;
    end else if (tlb.clrEn) begin
      for (int w = 0; w < WAYS; w++) begin
        validReg[tlb.clrSet][w] <= 1'b0; // R13
      end
    end else if (tlb.fillEn) begin
      validReg[fillSet][fillWay] <= 1'b1; // R7
      victimReg <= victimReg + 2'b01;
    end
  end

  // Tag and page data carry no reset
  always_ff @(posedge core_clk) begin
    if (tlb.fillEn && !tlb.clrEn) begin
      tagReg[fillSet][fillWay] <= fillTag;
      ppnReg[fillSet][fillWay] <= tlb.fillPpn;
    end
  end
endmodule // gam_tlb

// file: design/gam_tlb_if.sv
// Signals between the translation control and the translation cache
interface gam_tlb_if;
  import gam_pkg::*;
  logic [IDX_W-1:0] lkIdx;
  logic lkHit;
  logic [PPN_W-1:0] lkPpn;
  logic fillEn;
  logic [IDX_W-1:0] fillIdx;
  logic [PPN_W-1:0] fillPpn;
  logic clrEn;
  logic [5:0] clrSet;

  modport ctrl (output lkIdx, fillEn, fillIdx, fillPpn, clrEn, clrSet, input lkHit, lkPpn);
  modport cache (input lkIdx, fillEn, fillIdx, fillPpn, clrEn, clrSet, output lkHit, lkPpn);
endinterface

// file: tb/gam_core_addr_sva.sv
// Port-level checks for the address and translation block
module gam_core_addr_sva
  import gam_pkg::*;
#(
  parameter int FIFO_DEPTH = TRI_DEPTH
) (
  input wire logic core_clk, // Clock
  input wire logic nrst, // Reset
  input wire logic [WIN_W-1:0] regAddr, // Offset
  input wire logic [31:0] regWdata, // Wdata
  input wire logic regWr, // Write
  input wire logic regRd, // Read
  input wire logic [31:0] regRdata, // Rdata
  input wire logic xlReq, // Xl req
  input wire logic [LIN_W-1:0] xlAddr, // Linear
  input wire logic xlAck, // Xl ack
  input wire logic [31:0] xlPhys, // Phys
  input wire logic memReq, // Fetch req
  input wire logic [31:0] memAddr, // Fetch addr
  input wire logic memAck, // Fetch ack
  input wire logic [31:0] memRdata, // Fetch data
  input wire logic triValid, // Tri valid
  input wire logic [31:0] triData, // Tri data
  input wire logic tri2d, // Tri 2D
  input wire logic triReady, // Tri ready
  input wire logic ctrlStrobe, // Ctrl pulse
  input wire logic [WIN_W-1:0] ctrlAddr, // Ctrl addr
  input wire logic [31:0] ctrlData, // Ctrl data
  input wire logic mmuReady // Ready
);
  // ----------------------------------------------------------------
  // Enable shadow and init cycle count
  // ----------------------------------------------------------------
  logic enShadow_reg;
  logic [9:0] initCnt_reg;
  wire logic enWr = regWr && (regAddr == OFF_MMU_EN);
  wire logic enRise = enWr && regWdata[EN_BIT] && !enShadow_reg;
  // Count from each enable of a disabled unit
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      enShadow_reg <= 1'b0;
      initCnt_reg <= 10'h000;
    end else begin
      if (enWr) enShadow_reg <= regWdata[EN_BIT];
      if (enRise) initCnt_reg <= 10'h000;
      else if (initCnt_reg != 10'h3ff) initCnt_reg <= initCnt_reg + 10'h001;
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);
  rd_slot_a: assert property (regRdata != 32'h0000_0000 |-> $past(regRd))
    else $error("read data outside slot");
  ctrl_pulse_a: assert property (regWr && regAddr >= TRI_CTRL_BASE |=> ctrlStrobe &&
    ctrlAddr == $past(regAddr) && ctrlData == $past(regWdata)) else $error("ctrl write lost");
  ctrl_cause_a: assert property (ctrlStrobe |-> $past(regWr) && $past(regAddr) >= TRI_CTRL_BASE)
    else $error("ctrl pulse without cause");
  fetch_hold_a: assert property (memReq && !memAck |=> memReq && $stable(memAddr))
    else $error("fetch not held");
  fetch_drop_a: assert property (memReq && memAck |=> !memReq)
    else $error("fetch not dropped");
  fetch_addr_a: assert property ($rose(memReq) |-> memAddr[11:0] == {xlAddr[21:12], 2'b00})
    else $error("fetch word address wrong");
  bypass_map_a: assert property (xlReq && !xlAck && !enShadow_reg && !memReq |=>
    xlAck && xlPhys == {7'h00, $past(xlAddr)}) else $error("bypass map wrong");
  ack_pulse_a: assert property (xlAck |=> !xlAck)
    else $error("ack too long");
  page_off_a: assert property (xlAck |-> xlPhys[11:0] == xlAddr[11:0])
    else $error("page offset changed");
  init_hold_a: assert property (enShadow_reg && !mmuReady && !memReq |=> !xlAck)
    else $error("answer during init");
  ready_delay_a: assert property ($rose(mmuReady) |-> initCnt_reg inside {[10'h0fd:10'h102]})
    else $error("init length wrong");
  tri_hold_a: assert property (triValid && !triReady |=> triValid && $stable(triData))
    else $error("triangle word not held");
  fetch_phys_a: assert property (memReq && memAck |=> xlAck &&
    xlPhys[31:12] == $past(memRdata[31:12])) else $error("base not used");
  cover property (memReq && memAck);
  cover property ($rose(mmuReady));
  cover property (ctrlStrobe);
  cover property (triValid && triReady && tri2d);
endmodule // gam_core_addr_sva

bind gam_core_addr gam_core_addr_sva #(.FIFO_DEPTH(FIFO_DEPTH)) chk_u (.core_clk, .nrst,
  .regAddr, .regWdata, .regWr, .regRd, .regRdata, .xlReq, .xlAddr, .xlAck, .xlPhys, .memReq,
  .memAddr, .memAck, .memRdata, .triValid, .triData, .tri2d, .triReady, .ctrlStrobe,
  .ctrlAddr, .ctrlData, .mmuReady);

// file: tb/gam_mem_model.sv
// Behavioural system memory controller holding the translation table
module gam_mem_model (
  input wire logic core_clk, // Clock
  input wire logic nrst, // Reset
  input wire logic memReq, // Fetch req
  input wire logic [31:0] memAddr, // Word address
  output logic memAck, // Done pulse
  output logic [31:0] memRdata // Word
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [31:0] tbl [logic [31:0]];
  int latency = 0;
  int waitCnt = 0;
  initial memAck = 1'b0;
  initial memRdata = 32'h0000_0000;
  // ----------------------------------------------------------------
  // One fetch after a chosen wait; data scrambled outside the answer
  // ----------------------------------------------------------------
  always @(posedge core_clk) begin
    if (!nrst || memAck || !memReq) begin
      memAck <= 1'b0;
      waitCnt <= 0;
      memRdata <= ~memRdata;
    end else if (waitCnt >= latency) begin
      memAck <= 1'b1;
      memRdata <= tbl.exists(memAddr) ? tbl[memAddr] : ~memAddr;
    end else begin
      waitCnt <= waitCnt + 1;
      memRdata <= ~memRdata;
    end
  end
endmodule // gam_mem_model

// file: tb/tb_top.sv
// Self-checking bench for the address and translation block
module tb_top import gam_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int DEPTH = 8;
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  logic [WIN_W-1:0] regAddr = '0;
  logic [31:0] regWdata = '0;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic xlReq = 1'b0;
  logic triReady = 1'b0;
  logic [LIN_W-1:0] xlAddr = '0;
  logic [31:0] regRdata, xlPhys, memAddr, memRdata, triData, ctrlData;
  logic xlAck, memReq, memAck, triValid, tri2d, ctrlStrobe, mmuReady;
  logic [WIN_W-1:0] ctrlAddr;
  logic [31:0] ptrVal [8];
  int errorCnt = 0;
  int comparisons = 0;
  int cycleCnt = 0;
  gam_core_addr #(.FIFO_DEPTH(DEPTH)) dut_u (.core_clk, .nrst, .regAddr, .regWdata, .regWr,
    .regRd, .regRdata, .xlReq, .xlAddr, .xlAck, .xlPhys, .memReq, .memAddr, .memAck, .memRdata,
    .triValid, .triData, .tri2d, .triReady, .ctrlStrobe, .ctrlAddr, .ctrlData, .mmuReady);
  gam_mem_model mem_u (.core_clk, .nrst, .memReq, .memAddr, .memAck, .memRdata);
  // ----------------------------------------------------------------
  // Clock, watchdog and shared tasks
  // ----------------------------------------------------------------
  always #20 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cycleCnt <= cycleCnt + 1;
    if (cycleCnt == 20000) begin
      errorCnt++;
      $display("ERROR %0t watchdog expired", $time);
      print_verdict();
    end
  end
  task automatic print_verdict();
    $display("comparisons %0d errors %0d", comparisons, errorCnt);
    if (errorCnt == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      errorCnt++;
      $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic reg_wr(input logic [WIN_W-1:0] a, input logic [31:0] d);
    @(posedge core_clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge core_clk);
    regWr <= 1'b0;
  endtask
  task automatic reg_rd(input logic [WIN_W-1:0] a, output logic [31:0] d);
    @(posedge core_clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge core_clk);
    regRd <= 1'b0;
    #1 d = regRdata;
  endtask
  // Hold the request until the answer, then release it
  task automatic xl(input logic [LIN_W-1:0] a, output logic [31:0] p, output int n);
    @(posedge core_clk);
    xlReq <= 1'b1;
    xlAddr <= a;
    n = 0;
    do begin
      @(posedge core_clk);
      #1 n++;
    end while (xlAck !== 1'b1 && n < 600);
    p = xlPhys;
    chk(32'(xlAck), 32'h0000_0001, "answer seen");
    @(posedge core_clk);
    xlReq <= 1'b0;
  endtask
  task automatic wait_ready(output int n);
    n = 0;
    while (mmuReady !== 1'b1 && n < 400) begin
      @(posedge core_clk);
      #1 n++;
    end
    chk(32'(mmuReady), 32'h0000_0001, "ready seen");
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_regs();
    logic [31:0] d;
    logic [WIN_W-1:0] a;
    reg_rd(OFF_MMU_EN, d);
    chk(d, 32'h0000_0000, "enable at reset");
    for (int i = 0; i < TBL_PAGES; i++) begin
      a = OFF_PTR_BASE + 24'(4 * i);
      ptrVal[i] = {8'h30, 8'(i), 16'h5000};
      reg_rd(a, d);
      chk(d, PTR_RESET, "pointer at reset");
      reg_wr(a, ptrVal[i]);
      reg_rd(a, d);
      chk(d, ptrVal[i], "pointer readback");
    end
    reg_rd(24'h00_0100, d);
    chk(d, 32'h0000_0000, "unmapped read");
    $display("t_regs finished");
  endtask
  task automatic t_enable();
    logic [31:0] d;
    logic [31:0] p;
    int n;
    xl(25'h1ff_fffc, p, n);
    chk(p, 32'h01ff_fffc, "bypass phys");
    chk(32'(n), 32'h0000_0001, "bypass latency");
    reg_wr(OFF_MMU_EN, 32'h0000_0001);
    reg_rd(OFF_MMU_EN, d);
    chk(d, 32'h0000_0001, "ready during init");
    wait_ready(n);
    chk(32'(n >= 248 && n <= 258), 32'h0000_0001, "init length");
    reg_rd(OFF_MMU_EN, d);
    chk(d, 32'h0000_0003, "ready after init");
    $display("t_enable finished");
  endtask
  task automatic t_translate();
    logic [LIN_W-1:0] lin;
    logic [31:0] ent;
    logic [31:0] p;
    int n;
    for (int k = 0; k < TBL_PAGES; k++) begin
      lin = {3'(k), 10'(k * 37), 12'h9a4};
      ent = {4'hc, 4'(k), 12'h345, 12'hfff};
      mem_u.tbl[{ptrVal[k][31:12], lin[21:12], 2'b00}] = ent;
      mem_u.latency = (k % 3) * 3;
      xl(lin, p, n);
      chk(p, {ent[31:12], lin[11:0]}, "miss phys");
      xl(lin, p, n);
      chk(32'(n), 32'h0000_0001, "hit latency");
    end
    for (int pass = 0; pass < 2; pass++) begin
      for (int j = 0; j < 4; j++) begin
        lin = {13'(j * 64 + 5), 12'h010};
        ent = {20'(j + 'h7700), 12'h000};
        mem_u.tbl[{ptrVal[0][31:12], lin[21:12], 2'b00}] = ent;
        xl(lin, p, n);
        chk(p, {ent[31:12], lin[11:0]}, "shared set phys");
        if (pass == 1) chk(32'(n), 32'h0000_0001, "shared set hit");
      end
    end
    $display("t_translate finished");
  endtask
  task automatic t_update();
    logic [LIN_W-1:0] lin;
    logic [31:0] a;
    logic [31:0] p;
    int n;
    lin = {3'd2, 10'h155, 12'h0c8};
    a = {ptrVal[2][31:12], lin[21:12], 2'b00};
    mem_u.tbl[a] = 32'haaaa_1000;
    xl(lin, p, n);
    chk(p, 32'haaaa_10c8, "old entry");
    reg_wr(OFF_MMU_EN, 32'h0000_0000);
    xl(lin, p, n);
    chk(p, {7'h00, lin}, "bypass after disable");
    mem_u.tbl[a] = 32'hbbbb_2000;
    reg_wr(OFF_MMU_EN, 32'h0000_0001);
    wait_ready(n);
    xl(lin, p, n);
    chk(p, 32'hbbbb_20c8, "fresh entry");
    $display("t_update finished");
  endtask
  task automatic t_tri();
    logic [31:0] d;
    int n;
    for (int i = 0; i < DEPTH + 3; i++) reg_wr(i % 2 ? TRI_2D_BASE : TRI_DATA_BASE, 32'(i));
    reg_rd(OFF_STATUS, d);
    chk(32'(d[OVF_BIT]), 32'h0000_0001, "overflow flag");
    chk(d >> LEVEL_LSB, 32'(DEPTH), "fifo level");
    reg_wr(OFF_STATUS, 32'h0000_0001);
    reg_rd(OFF_STATUS, d);
    chk(32'(d[OVF_BIT]), 32'h0000_0000, "overflow clear");
    n = 0;
    @(posedge core_clk);
    triReady <= 1'b1;
    for (int t = 0; t < 40; t++) begin
      #1 if (triValid === 1'b1) begin
        chk(triData, 32'(n), "triangle order");
        chk(32'(tri2d), 32'(n % 2), "region mark");
        n++;
      end
      @(posedge core_clk);
    end
    triReady <= 1'b0;
    chk(32'(n >= DEPTH && n < DEPTH + 3), 32'h0000_0001, "word count");
    for (int i = 0; i < 2; i++) begin
      reg_wr(i ? 24'hff_fffc : TRI_CTRL_BASE, 32'hc0de_0000 + 32'(i));
      #1 chk(32'(ctrlStrobe), 32'h0000_0001, "ctrl pulse");
      chk(32'(ctrlAddr), i ? 32'h00ff_fffc : 32'h00c0_0000, "ctrl addr");
      chk(ctrlData, 32'hc0de_0000 + 32'(i), "ctrl data");
    end
    $display("t_tri finished");
  endtask
  initial begin
    repeat (4) @(posedge core_clk);
    nrst <= 1'b1;
    t_regs();
    t_enable();
    t_translate();
    t_update();
    t_tri();
    print_verdict();
  end
endmodule // tb_top
